// ==== ict_pkg.sv ====
// Constants for the instruction cycle timing sequencer.
// Assumes one clock domain; all figures are processor clock periods and bus cycles.
package ict_pkg;

   // Operation classes requested by the decoder
   typedef enum logic [5:0] {
      ICT_JUMP, ICT_CALL, ICT_BLK_M2R, ICT_BLK_R2M,
      ICT_XADD_REG, ICT_XADD_MEM, ICT_MCMP, ICT_DADD_REG, ICT_DADD_MEM,
      ICT_LOGIC_ST, ICT_BND, ICT_MOVE_TO_ST, ICT_RESET_INSN, ICT_XRET, ICT_RTS, ICT_STOP,
      ICT_LINK, ICT_UNLINK, ICT_USTK_MOVE, ICT_NOP, ICT_SWAP,
      ICT_PERI_R2M, ICT_PERI_M2R,
      ICT_ADDR_ERR, ICT_BUS_ERR, ICT_INTERRUPT, ICT_DIV_ZERO, ICT_ILLEGAL, ICT_PRIV, ICT_TRACE,
      ICT_TRAP, ICT_BND_TRAP, ICT_OVF_TAKEN, ICT_OVF_NOT
   } ict_op_type;

   localparam logic [7:0] ICT_JUMP_CLK      = 8'h08;
   localparam logic [7:0] ICT_CALL_CLK      = 8'h10;
   localparam logic [7:0] ICT_MM_M2R_BASE   = 8'h0C;
   localparam logic [7:0] ICT_MM_R2M_BASE   = 8'h08;
   localparam logic [7:0] ICT_MM_WORD_STEP  = 8'h04;
   localparam logic [7:0] ICT_MM_LONG_STEP  = 8'h08;
   localparam logic [7:0] ICT_X_REG_BW      = 8'h04;
   localparam logic [7:0] ICT_X_REG_L       = 8'h08;
   localparam logic [7:0] ICT_X_MEM_BW      = 8'h12;
   localparam logic [7:0] ICT_X_MEM_L       = 8'h1E;
   localparam logic [7:0] ICT_MCMP_BW       = 8'h0C;
   localparam logic [7:0] ICT_MCMP_L        = 8'h14;
   localparam logic [7:0] ICT_BCD_REG       = 8'h06;
   localparam logic [7:0] ICT_BCD_MEM       = 8'h12;
   localparam logic [7:0] ICT_LOGIC_SR_CLK  = 8'h14;
   localparam logic [7:0] ICT_BND_CLK       = 8'h0A;
   localparam logic [7:0] ICT_TO_ST_CLK     = 8'h0C;
   localparam logic [7:0] ICT_RESET_CLK     = 8'h84;
   localparam logic [7:0] ICT_XRET_CLK      = 8'h14;
   localparam logic [7:0] ICT_RTS_CLK       = 8'h10;
   localparam logic [7:0] ICT_SHORT_CLK     = 8'h04;
   localparam logic [7:0] ICT_LINK_CLK      = 8'h10;
   localparam logic [7:0] ICT_UNLINK_CLK    = 8'h0C;
   localparam logic [7:0] ICT_PERI_W_CLK    = 8'h10;
   localparam logic [7:0] ICT_PERI_L_CLK    = 8'h18;
   localparam logic [7:0] ICT_BUSERR_CLK    = 8'h32;
   localparam logic [7:0] ICT_INTR_CLK      = 8'h2C;
   localparam logic [7:0] ICT_DIVZ_CLK      = 8'h2A;
   localparam logic [7:0] ICT_ILL_CLK       = 8'h22;
   localparam logic [7:0] ICT_TRAP_CLK      = 8'h26;
   localparam logic [7:0] ICT_CHKTRAP_CLK   = 8'h2C;
   localparam logic [7:0] ICT_STARTUP_CLK   = 8'h28;
   localparam logic [3:0] ICT_STARTUP_RD    = 4'h6;

endpackage : ict_pkg

// ==== ict_sync.sv ====
// Two-flop synchroniser for one pin level.
// Assumes the pin is asynchronous to mclk.
`timescale 1ns/1ps
`default_nettype none
module ict_sync
(
   input  wire  logic mclk,
   input  wire  logic rst,
   input  wire  logic pin,
   output logic       level
);
   typedef struct packed { logic s1; logic s2; } ict_sync_type;
   ict_sync_type st_q;
   ict_sync_type st_d;

   // First stage feeds only the second
   always_comb
   begin
      st_d    = st_q;
      st_d.s1 = pin;
      st_d.s2 = st_q.s1;
   end

   always_ff @(posedge mclk)
   begin
      if (rst)
         st_q <= '0;
      else
         st_q <= st_d;
   end

   assign level = st_q.s2;
endmodule : ict_sync
`default_nettype wire

// ==== ict_counter.sv ====
// Down counter of clock periods for one operation.
// Assumes load and the count come from the same clock domain.
`timescale 1ns/1ps
`default_nettype none
module ict_counter
(
   input  wire  logic       mclk,
   input  wire  logic       rst,
   input  wire  logic       load,
   input  wire  logic [9:0] value,
   output logic             busy,
   output logic             last
);
   typedef struct packed { logic [9:0] cnt; } ict_counter_type;
   ict_counter_type st_q;
   ict_counter_type st_d;

   // Load wins; otherwise count down to zero
   always_comb
   begin
      st_d = st_q;
      if (load)
         st_d.cnt = value;
      else if (st_q.cnt != 10'h000)
         st_d.cnt = st_q.cnt - 10'h001;
   end

   always_ff @(posedge mclk)
   begin
      if (rst)
         st_q <= '0;
      else
         st_q <= st_d;
   end

   assign busy = (st_q.cnt != 10'h000);
   assign last = (st_q.cnt == 10'h001);
endmodule : ict_counter
`default_nettype wire

// ==== ict_sequencer.sv ====
// Instruction cycle timing sequencer: given an operation class, runs it for its clock count
// and its bus read and write cycle counts, then reports done.
// Assumes the decoder holds op fields while start is high; bus answers with no wait states.
// Notes on behaviour
// - jump takes 8 clocks 2 reads; subroutine jump 16 clocks 2 reads 2 writes.
// - register block move: from memory 12 plus 4n/8n; to memory 8 plus 4n/8n.
// - index register size never changes execution time.
// - extended add/subtract 4 or 8 register; memory 18 (3/1) or long 30 (5/2).
// - memory compare postincrement 12 (3/0), long 20 (5/0).
// - decimal add/subtract 6 (1/0) register, 18 (3/1) memory.
// - logical immediate to condition byte or status word 20 clocks, three reads.
// - memory operands add address calculation; bounds 10 (1/0), status moves 12 (1/0).
// - reset 132 (1/0), exception return 20 (5/0), return 16 (4/0), stop 4 (0/0).
// - frame link 16 (2/2), unlink 12 (3/0); stack pointer, nop, swap 4 (1/0).
// - peripheral moves: to memory 16 (2/2) or 24 (2/4); from 16 (4/0) or 24 (6/0).
// - address or bus error exception 50 clocks, four reads, seven writes.
// - interrupt exception 44 (5/3), assuming four-clock acknowledge cycle.
// - after reset and halt negate, execution starts 40 clocks later, six reads.
// - divide by zero 42 (5/3); illegal, privilege, trace 34 (4/3); trap 38 (4/3).
// - trapping bounds 44 (5/3) plus address time; overflow trap 34 taken, 4 (1/0) not.
`timescale 1ns/1ps
`default_nettype none
module ict_sequencer
(
   input  wire  logic              mclk,
   input  wire  logic              rst,
   input  wire  logic              reset_pin_n,
   input  wire  logic              halt_pin_n,
   input  wire  logic              start,
   input  wire  ict_pkg::ict_op_type op,
   input  wire  logic              long_size,
   input  wire  logic [4:0]        reg_count,
   input  wire  logic              index_long,
   input  wire  logic [7:0]        ea_clocks,
   input  wire  logic [3:0]        ea_reads,
   output logic                    busy,
   output logic                    done,
   output logic                    running,
   output logic [9:0]              clocks_total,
   output logic [5:0]              reads_total,
   output logic [3:0]              writes_total
);
   typedef enum { ICT_IDLE_HOLD, ICT_STARTUP, ICT_READY, ICT_EXEC } ict_state_type;

   typedef struct packed {
      ict_state_type st;
      logic          busy;
      logic          done;
      logic          running;
      logic [9:0]    clk;
      logic [5:0]    rd;
      logic [3:0]    wr;
   } ict_seq_type;

   ict_seq_type s_q;
   ict_seq_type s_d;

   logic       rst_lvl_n;
   logic       halt_lvl_n;
   logic       cnt_load;
   logic [9:0] cnt_value;
   logic       cnt_busy;
   logic       cnt_last;
   logic [7:0] base;
   logic [5:0] rd;
   logic [3:0] wr;
   logic       add_ea;
   logic [9:0] step;
   logic [5:0] rstep;
   logic [3:0] wstep;

   ////////////////////////////////////////////////////////////////////////////////
   // Pin inputs
   ict_sync u_sync_reset
   (
      .mclk  (mclk),
      .rst   (rst),
      .pin   (reset_pin_n),
      .level (rst_lvl_n)
   );

   ict_sync u_sync_halt
   (
      .mclk  (mclk),
      .rst   (rst),
      .pin   (halt_pin_n),
      .level (halt_lvl_n)
   );

   ict_counter u_cnt
   (
      .mclk  (mclk),
      .rst   (rst),
      .load  (cnt_load),
      .value (cnt_value),
      .busy  (cnt_busy),
      .last  (cnt_last)
   );

   ////////////////////////////////////////////////////////////////////////////////
   // Timing table: base clocks and bus cycles per class
   // index_long is read nowhere: indexed modes cost the same either way
   always_comb
   begin
      base   = ict_pkg::ICT_SHORT_CLK;
      rd     = 6'h01;
      wr     = 4'h0;
      add_ea = 1'b0;
      step   = 10'h000;
      rstep  = 6'h00;
      wstep  = 4'h0;
      case (op)
         ict_pkg::ICT_JUMP:       begin base = ict_pkg::ICT_JUMP_CLK; rd = 6'h02; end
         ict_pkg::ICT_CALL:       begin base = ict_pkg::ICT_CALL_CLK; rd = 6'h02; wr = 4'h2; end
         ict_pkg::ICT_BLK_M2R:
         begin
            base  = ict_pkg::ICT_MM_M2R_BASE;
            rd    = 6'h03;
            step  = long_size ? {2'b00, ict_pkg::ICT_MM_LONG_STEP} : {2'b00, ict_pkg::ICT_MM_WORD_STEP};
            rstep = long_size ? 6'h02 : 6'h01;
         end
         ict_pkg::ICT_BLK_R2M:
         begin
            base  = ict_pkg::ICT_MM_R2M_BASE;
            rd    = 6'h02;
            step  = long_size ? {2'b00, ict_pkg::ICT_MM_LONG_STEP} : {2'b00, ict_pkg::ICT_MM_WORD_STEP};
            wstep = long_size ? 4'h2 : 4'h1;
         end
         ict_pkg::ICT_XADD_REG:   base = long_size ? ict_pkg::ICT_X_REG_L : ict_pkg::ICT_X_REG_BW;
         ict_pkg::ICT_XADD_MEM:
         begin
            base = long_size ? ict_pkg::ICT_X_MEM_L : ict_pkg::ICT_X_MEM_BW;
            rd   = long_size ? 6'h05 : 6'h03;
            wr   = long_size ? 4'h2 : 4'h1;
         end
         ict_pkg::ICT_MCMP:
         begin
            base = long_size ? ict_pkg::ICT_MCMP_L : ict_pkg::ICT_MCMP_BW;
            rd   = long_size ? 6'h05 : 6'h03;
         end
         ict_pkg::ICT_DADD_REG:   base = ict_pkg::ICT_BCD_REG;
         ict_pkg::ICT_DADD_MEM:   begin base = ict_pkg::ICT_BCD_MEM; rd = 6'h03; wr = 4'h1; end
         ict_pkg::ICT_LOGIC_ST:   begin base = ict_pkg::ICT_LOGIC_SR_CLK; rd = 6'h03; end
         ict_pkg::ICT_BND:        begin base = ict_pkg::ICT_BND_CLK; add_ea = 1'b1; end
         ict_pkg::ICT_MOVE_TO_ST: begin base = ict_pkg::ICT_TO_ST_CLK; add_ea = 1'b1; end
         ict_pkg::ICT_RESET_INSN: base = ict_pkg::ICT_RESET_CLK;
         ict_pkg::ICT_XRET:       begin base = ict_pkg::ICT_XRET_CLK; rd = 6'h05; end
         ict_pkg::ICT_RTS:        begin base = ict_pkg::ICT_RTS_CLK; rd = 6'h04; end
         ict_pkg::ICT_STOP:       rd = 6'h00;
         ict_pkg::ICT_LINK:       begin base = ict_pkg::ICT_LINK_CLK; rd = 6'h02; wr = 4'h2; end
         ict_pkg::ICT_UNLINK:     begin base = ict_pkg::ICT_UNLINK_CLK; rd = 6'h03; end
         ict_pkg::ICT_USTK_MOVE,
         ict_pkg::ICT_NOP,
         ict_pkg::ICT_SWAP,
         ict_pkg::ICT_OVF_NOT:    base = ict_pkg::ICT_SHORT_CLK;
         ict_pkg::ICT_PERI_R2M:
         begin
            base = long_size ? ict_pkg::ICT_PERI_L_CLK : ict_pkg::ICT_PERI_W_CLK;
            rd   = 6'h02;
            wr   = long_size ? 4'h4 : 4'h2;
         end
         ict_pkg::ICT_PERI_M2R:
         begin
            base = long_size ? ict_pkg::ICT_PERI_L_CLK : ict_pkg::ICT_PERI_W_CLK;
            rd   = long_size ? 6'h06 : 6'h04;
         end
         ict_pkg::ICT_ADDR_ERR,
         ict_pkg::ICT_BUS_ERR:    begin base = ict_pkg::ICT_BUSERR_CLK; rd = 6'h04; wr = 4'h7; end
         ict_pkg::ICT_INTERRUPT:  begin base = ict_pkg::ICT_INTR_CLK; rd = 6'h05; wr = 4'h3; end
         ict_pkg::ICT_DIV_ZERO:   begin base = ict_pkg::ICT_DIVZ_CLK; rd = 6'h05; wr = 4'h3; end
         ict_pkg::ICT_ILLEGAL,
         ict_pkg::ICT_PRIV,
         ict_pkg::ICT_TRACE:      begin base = ict_pkg::ICT_ILL_CLK; rd = 6'h04; wr = 4'h3; end
         ict_pkg::ICT_TRAP:       begin base = ict_pkg::ICT_TRAP_CLK; rd = 6'h04; wr = 4'h3; end
         ict_pkg::ICT_BND_TRAP:
         begin
            base   = ict_pkg::ICT_CHKTRAP_CLK;
            rd     = 6'h05;
            wr     = 4'h3;
            add_ea = 1'b1;
         end
         ict_pkg::ICT_OVF_TAKEN:  begin base = ict_pkg::ICT_ILL_CLK; rd = 6'h04; wr = 4'h3; end
         default:                 base = ict_pkg::ICT_SHORT_CLK;
      endcase
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Totals: base plus per-register steps plus address time
   logic [9:0] tot_clk;
   logic [5:0] tot_rd;
   logic [3:0] tot_wr;
   logic       take;

   always_comb
   begin
      tot_clk = {2'b00, base}
              + 10'(step * {5'h00, reg_count})
              + (add_ea ? {2'b00, ea_clocks} : 10'h000);
      tot_rd  = rd + 6'(rstep * {1'b0, reg_count}) + (add_ea ? {2'b00, ea_reads} : 6'h00);
      tot_wr  = wr + 4'(wstep * reg_count[3:0]);
      take    = (s_q.st == ICT_READY) && start;
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Counter load: startup sequence or an accepted operation
   always_comb
   begin
      cnt_load  = 1'b0;
      cnt_value = 10'h000;
      if ((s_q.st == ICT_IDLE_HOLD) && rst_lvl_n && halt_lvl_n)
      begin
         cnt_load  = 1'b1;
         cnt_value = {2'b00, ict_pkg::ICT_STARTUP_CLK};
      end
      else if (take)
      begin
         cnt_load  = 1'b1;
         cnt_value = tot_clk;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Control state
   // Wait states are not modelled; the counts assume zero-wait bus answers
   always_comb
   begin
      s_d      = s_q;
      s_d.done = 1'b0;
      case (s_q.st)
         ICT_IDLE_HOLD:
         begin
            s_d.running = 1'b0;
            if (rst_lvl_n && halt_lvl_n)
            begin
               s_d.st   = ICT_STARTUP;
               s_d.busy = 1'b1;
               s_d.clk  = {2'b00, ict_pkg::ICT_STARTUP_CLK};
               s_d.rd   = {2'b00, ict_pkg::ICT_STARTUP_RD};
               s_d.wr   = 4'h0;
            end
         end
         ICT_STARTUP:
         begin
            if (cnt_last)
            begin
               s_d.st      = ICT_READY;
               s_d.busy    = 1'b0;
               s_d.done    = 1'b1;
               s_d.running = 1'b1;
            end
         end
         ICT_READY:
         begin
            if (take)
            begin
               s_d.st   = ICT_EXEC;
               s_d.busy = 1'b1;
               s_d.clk  = tot_clk;
               s_d.rd   = tot_rd;
               s_d.wr   = tot_wr;
            end
         end
         ICT_EXEC:
         begin
            if (cnt_last || !cnt_busy)
            begin
               s_d.st   = ICT_READY;
               s_d.busy = 1'b0;
               s_d.done = 1'b1;
            end
         end
         default: s_d.st = ICT_IDLE_HOLD;
      endcase
      // Reset or halt asserted again restarts the startup sequence
      if (!(rst_lvl_n && halt_lvl_n))
      begin
         s_d.st      = ICT_IDLE_HOLD;
         s_d.busy    = 1'b0;
         s_d.running = 1'b0;
         s_d.done    = 1'b0;
      end
   end

   always_ff @(posedge mclk)
   begin
      if (rst)
      begin
         s_q.st      <= ICT_IDLE_HOLD;
         s_q.busy    <= 1'b0;
         s_q.done    <= 1'b0;
         s_q.running <= 1'b0;
         s_q.clk     <= 10'h000;
         s_q.rd      <= 6'h00;
         s_q.wr      <= 4'h0;
      end
      else
         s_q <= s_d;
   end

   assign busy         = s_q.busy;
   assign done         = s_q.done;
   assign running      = s_q.running;
   assign clocks_total = s_q.clk;
   assign reads_total  = s_q.rd;
   assign writes_total = s_q.wr;
endmodule : ict_sequencer
`default_nettype wire

// ==== ict_checker.sv ====
// Port checker for the cycle timing sequencer.
// Assumes it is bound onto ict_sequencer and sees only its ports.
`timescale 1ns/1ps
`default_nettype none
module ict_checker
(
   input wire logic                mclk,
   input wire logic                rst,
   input wire logic                reset_pin_n,
   input wire logic                halt_pin_n,
   input wire logic                start,
   input wire ict_pkg::ict_op_type op,
   input wire logic                long_size,
   input wire logic [4:0]          reg_count,
   input wire logic                index_long,
   input wire logic [7:0]          ea_clocks,
   input wire logic [3:0]          ea_reads,
   input wire logic                busy,
   input wire logic                done,
   input wire logic                running,
   input wire logic [9:0]          clocks_total,
   input wire logic [5:0]          reads_total,
   input wire logic [3:0]          writes_total
);
   default clocking @(posedge mclk); endclocking
   default disable iff (rst);
   logic [9:0] cnt_q;
   logic [9:0] cnt_d;
   logic       take;
   // Busy length counter; a pin assertion cancels the run, so the count restarts
   always_comb
   begin
      cnt_d = (busy && reset_pin_n && halt_pin_n) ? cnt_q + 10'h001 : 10'h000;
      take = start && running && !busy;
   end
   always_ff @(posedge mclk)
   begin
      cnt_q <= rst ? 10'h000 : cnt_d;
   end
   ////////////////////////////////////////////////////////////////////////////////
   AST_DONE_TIME: assert property (done |-> cnt_q == clocks_total)
      else $error("done after wrong number of busy cycles");
   AST_TAKE_BUSY: assert property (take |=> busy && !done)
      else $error("accepted request did not start");
   AST_DONE_PULSE: assert property (done |=> !done)
      else $error("done longer than one cycle");
   AST_DONE_IDLE: assert property (done |-> !busy && running)
      else $error("done while still busy");
   AST_JUMP: assert property (take && op == ict_pkg::ICT_JUMP |=>
      clocks_total == 10'h008 && reads_total == 6'h02 && writes_total == 4'h0) else $error("jump totals");
   AST_BLKMOVE: assert property (take && op == ict_pkg::ICT_BLK_R2M && long_size |=>
      clocks_total == 10'h008 + {2'h0, $past(reg_count), 3'h0}) else $error("block move clocks");
   AST_XMEM: assert property (take && op == ict_pkg::ICT_XADD_MEM && !long_size |=>
      clocks_total == 10'h012 && reads_total == 6'h03 && writes_total == 4'h1) else $error("extended add totals");
   AST_ERR: assert property (take && op inside {ict_pkg::ICT_ADDR_ERR, ict_pkg::ICT_BUS_ERR} |=>
      clocks_total == 10'h032 && reads_total == 6'h04 && writes_total == 4'h7) else $error("error totals");
   AST_CHKTRAP: assert property (take && op == ict_pkg::ICT_BND_TRAP |=>
      clocks_total == 10'h02c + $past(ea_clocks) && reads_total == 6'h05 + $past(ea_reads))
      else $error("bounds trap totals");
   AST_STARTUP: assert property ($rose(running) |-> done && clocks_total == 10'h028
      && reads_total == 6'h06 && writes_total == 4'h0) else $error("startup totals");
   // Main scenarios reached
   COV_BLKMOVE: cover property (take && op == ict_pkg::ICT_BLK_M2R);
   COV_DONE: cover property (done);
   COV_BOOT: cover property ($rose(running));
endmodule : ict_checker
bind ict_sequencer ict_checker i_ict_checker (.mclk(mclk), .rst(rst), .reset_pin_n(reset_pin_n),
   .halt_pin_n(halt_pin_n), .start(start), .op(op), .long_size(long_size), .reg_count(reg_count),
   .index_long(index_long), .ea_clocks(ea_clocks), .ea_reads(ea_reads), .busy(busy), .done(done),
   .running(running), .clocks_total(clocks_total), .reads_total(reads_total), .writes_total(writes_total));
`default_nettype wire

// ==== ict_pin_model.sv ====
// System side model: drives the reset and halt pins off the clock edge.
// Assumes mclk from the bench; a rising pulse_req asks for one reset pulse.
`timescale 1ns/1ps
`default_nettype none
module ict_pin_model
(
   input  wire logic mclk,
   input  wire logic pulse_req,
   output logic      reset_pin_n,
   output logic      halt_pin_n
);
   // Bus answers assumed with no wait states, so no stall is modelled
   initial
   begin
      reset_pin_n = 1'b0;
      halt_pin_n = 1'b0;
      repeat (14) @(posedge mclk);
      #1.3 halt_pin_n = 1'b1;
      #0.9 reset_pin_n = 1'b1;
      forever
      begin
         @(posedge pulse_req);
         #2.1 reset_pin_n = 1'b0;
         halt_pin_n = 1'b0;
         // Held past the ten-period minimum; halt freed a cycle early
         repeat (12) @(posedge mclk);
         #1.7 halt_pin_n = 1'b1;
         @(posedge mclk);
         #3.1 reset_pin_n = 1'b1;
      end
   end
endmodule : ict_pin_model
`default_nettype wire

// ==== instruction_cycle_timing_tb_top.sv ====
// Self-checking bench for the cycle timing sequencer.
// Assumes the pin model and the bound checker beside the design.
`timescale 1ns/1ps
`default_nettype none
module instruction_cycle_timing_tb_top;
   logic mclk, rst, pulse_req, reset_pin_n, halt_pin_n, start, long_size, index_long, busy, done, running;
   ict_pkg::ict_op_type op;
   logic [4:0]          reg_count;
   logic [7:0]          ea_clocks;
   logic [3:0]          ea_reads, writes_total;
   logic [9:0]          clocks_total;
   logic [5:0]          reads_total;
   int                  n_mismatch = 0;
   int                  checks_done = 0;
   // 200 MHz clock
   initial
   begin
      mclk = 1'b0;
      forever #2.5 mclk = ~mclk;
   end
   ict_pin_model i_ict_pin_model (.mclk(mclk), .pulse_req(pulse_req), .reset_pin_n(reset_pin_n),
      .halt_pin_n(halt_pin_n));
   ict_sequencer i_ict_sequencer (.mclk(mclk), .rst(rst), .reset_pin_n(reset_pin_n), .halt_pin_n(halt_pin_n),
      .start(start), .op(op), .long_size(long_size), .reg_count(reg_count), .index_long(index_long),
      .ea_clocks(ea_clocks), .ea_reads(ea_reads), .busy(busy), .done(done), .running(running),
      .clocks_total(clocks_total), .reads_total(reads_total), .writes_total(writes_total));
   ////////////////////////////////////////////////////////////////////////////////
   task automatic close_out();
      $display("checks %0d mismatches %0d", checks_done, n_mismatch);
      if (n_mismatch == 0 && checks_done > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask : close_out
   task automatic cmp(string what, logic [9:0] exp, logic [9:0] seen);
      checks_done++;
      if (seen !== exp)
      begin
         n_mismatch++;
         $display("BAD %s expected %0d seen %0d", what, exp, seen);
      end
   endtask : cmp
   // Expected figures packed as clocks*4096 + reads*64 + writes
   function automatic int t(int c, int r, int w);
      return c * 4096 + r * 64 + w;
   endfunction : t
   function automatic int expect_of(ict_pkg::ict_op_type o, int l, int n, int ec, int er);
      case (o)
         ict_pkg::ICT_JUMP: return t(8, 2, 0);
         ict_pkg::ICT_CALL: return t(16, 2, 2);
         ict_pkg::ICT_BLK_M2R: return l ? t(12 + 8 * n, 3 + 2 * n, 0) : t(12 + 4 * n, 3 + n, 0);
         ict_pkg::ICT_BLK_R2M: return l ? t(8 + 8 * n, 2, 2 * n) : t(8 + 4 * n, 2, n);
         ict_pkg::ICT_XADD_REG: return t(l ? 8 : 4, 1, 0);
         ict_pkg::ICT_XADD_MEM: return l ? t(30, 5, 2) : t(18, 3, 1);
         ict_pkg::ICT_MCMP: return l ? t(20, 5, 0) : t(12, 3, 0);
         ict_pkg::ICT_DADD_REG: return t(6, 1, 0);
         ict_pkg::ICT_DADD_MEM: return t(18, 3, 1);
         ict_pkg::ICT_LOGIC_ST: return t(20, 3, 0);
         ict_pkg::ICT_BND: return t(10 + ec, 1 + er, 0);
         ict_pkg::ICT_MOVE_TO_ST: return t(12 + ec, 1 + er, 0);
         ict_pkg::ICT_RESET_INSN: return t(132, 1, 0);
         ict_pkg::ICT_XRET: return t(20, 5, 0);
         ict_pkg::ICT_RTS: return t(16, 4, 0);
         ict_pkg::ICT_STOP: return t(4, 0, 0);
         ict_pkg::ICT_LINK: return t(16, 2, 2);
         ict_pkg::ICT_UNLINK: return t(12, 3, 0);
         ict_pkg::ICT_PERI_R2M: return l ? t(24, 2, 4) : t(16, 2, 2);
         ict_pkg::ICT_PERI_M2R: return l ? t(24, 6, 0) : t(16, 4, 0);
         ict_pkg::ICT_ADDR_ERR, ict_pkg::ICT_BUS_ERR: return t(50, 4, 7);
         ict_pkg::ICT_INTERRUPT: return t(44, 5, 3);
         ict_pkg::ICT_DIV_ZERO: return t(42, 5, 3);
         ict_pkg::ICT_TRAP: return t(38, 4, 3);
         ict_pkg::ICT_BND_TRAP: return t(44 + ec, 5 + er, 3);
         ict_pkg::ICT_ILLEGAL, ict_pkg::ICT_PRIV, ict_pkg::ICT_TRACE: return t(34, 4, 3);
         ict_pkg::ICT_OVF_TAKEN: return t(34, 4, 3);
         default: return t(4, 1, 0);
      endcase
   endfunction : expect_of
   // Entered at a falling edge; leaves start high so the next request follows done at once
   task automatic run_op(ict_pkg::ict_op_type o, logic l, logic [4:0] n, logic [7:0] ec, logic [3:0] er);
      int e;
      int cyc;
      e = expect_of(o, l, n, ec, er);
      start = 1'b1;
      op = o;
      long_size = l;
      reg_count = n;
      ea_clocks = ec;
      ea_reads = er;
      index_long = 1'($urandom);
      @(negedge mclk);
      // Fields changed while busy must be ignored
      op = ict_pkg::ict_op_type'($urandom_range(0, 33));
      long_size = ~l;
      reg_count = ~n;
      index_long = ~index_long;
      cyc = 0;
      while (done !== 1'b1 && cyc < 400)
      begin
         @(negedge mclk);
         cyc++;
      end
      // Busy for N periods after the taking edge, done seen at the N-th falling edge
      cmp("cycles", 10'(e / 4096), 10'(cyc));
      cmp("clocks", 10'(e / 4096), clocks_total);
      cmp("reads", 10'(e / 64 % 64), {4'h0, reads_total});
      cmp("writes", 10'(e % 64), {6'h00, writes_total});
      if (cyc >= 400)
      begin
         n_mismatch++;
         close_out();
      end
   endtask : run_op
   task automatic wait_boot();
      int cyc;
      cyc = 0;
      while (done !== 1'b1 && cyc < 300)
      begin
         @(negedge mclk);
         cyc++;
      end
      cmp("boot clocks", 10'h028, clocks_total);
      cmp("boot reads", 10'h006, {4'h0, reads_total});
      cmp("boot writes", 10'h000, {6'h00, writes_total});
      cmp("running", 10'h001, {9'h000, running});
      if (cyc >= 300)
      begin
         n_mismatch++;
         close_out();
      end
   endtask : wait_boot
   ////////////////////////////////////////////////////////////////////////////////
   initial
   begin
      int k;
      rst = 1'b1;
      pulse_req = 1'b0;
      start = 1'b0;
      op = ict_pkg::ICT_NOP;
      long_size = 1'b0;
      reg_count = 5'h00;
      index_long = 1'b0;
      ea_clocks = 8'h00;
      ea_reads = 4'h0;
      k = $urandom(32'h4112_5c17);
      repeat (12) @(negedge mclk);
      cmp("idle", 10'h000, {7'h00, busy, done, running});
      rst = 1'b0;
      wait_boot();
      // Every class, short and long sizes, then seven registers and the largest address time
      for (int p = 0; p < 3; p++)
         for (int i = 0; i < 34; i++)
            run_op(ict_pkg::ict_op_type'(i), p[0], p == 2 ? 5'h07 : 5'($urandom_range(0, 6)),
               p == 2 ? 8'hff : 8'($urandom), 4'($urandom));
      start = 1'b0;
      pulse_req = 1'b1;
      repeat (5) @(negedge mclk);
      cmp("stopped", 10'h000, {9'h000, running});
      wait_boot();
      run_op(ict_pkg::ICT_NOP, 1'b0, 5'h00, 8'h00, 4'h0);
      close_out();
   end
endmodule : instruction_cycle_timing_tb_top
`default_nettype wire
